// file: operator_model.sv
/* operator at the panel: presses the restore button on request and
   counts changes of the device lamp red drive. assumes one clock. */
`timescale 1ns/1ps
module operator_model (
	// clock
	input wire logic i_clk,
	// bench request and lamp seen
	input wire logic i_press,
	input wire logic i_red,
	// button contact and red change count
	output logic o_button,
	output logic [7:0] o_red_changes
);
	logic red_q = 1'b0; // last red level seen
	initial o_button = 1'b0;
	initial o_red_changes = 8'h00;
	// a finger is slow: contact follows the request a cycle late
	always @(posedge i_clk) begin
		o_button <= i_press;
		red_q <= i_red;
		o_red_changes <= o_red_changes + 8'(red_q !== i_red);
	end
endmodule : operator_model

// file: port_ind_if.sv
/*
 * Carrier between the controller and one port indicator slice.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface port_ind_if;
	logic link;          // port has link
	logic act;           // one-cycle frame activity pulse
	logic conn;          // protocol connection established
	logic blink;         // common blink phase
	logic [31:0] hold;   // activity hold time in cycles
	logic green;         // registered green drive
	logic amber;         // registered amber drive
	logic [1:0] state;   // registered indication code

	modport ctrl (output link, act, conn, blink, hold, input green, amber, state);
	modport slice (input link, act, conn, blink, hold, output green, amber, state);
endinterface : port_ind_if

// file: port_indicator.sv
/*
 * One Ethernet port lamp: off, green, blinking amber or amber.
 * Assumes activity pulses and link are synchronous to i_clk.
 */
`timescale 1ns/1ps
module port_indicator
	import status_ind_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// controller side
	port_ind_if.slice p
);
	typedef enum logic [1:0] {PS_OFF, PS_GREEN, PS_AMBER_BLINK, PS_AMBER} port_state_t;

	logic [31:0] act_cnt_q;   // hold cycles left after the last frame
	logic [31:0] act_cnt_d;
	wire active = (act_cnt_q != 32'h0);
	port_state_t st;          // indication chosen this cycle

	// retrigger on every frame; the hold makes sporadic frames visible
	assign act_cnt_d = p.act ? p.hold : (active ? act_cnt_q - 32'h1 : act_cnt_q);

	always_ff @(posedge i_clk) begin
		if (i_srst || !p.link) begin
			act_cnt_q <= 32'h0;
		end else begin
			act_cnt_q <= act_cnt_d;
		end
	end

	// choose the indication from this port only
	always_comb begin
		if (!p.link) begin
			st = PS_OFF;
		end else if (active && p.conn) begin
			st = PS_AMBER;
		end else if (active) begin
			st = PS_AMBER_BLINK;
		end else begin
			st = PS_GREEN;
		end
	end

	// drive lamps from flops
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			p.green <= 1'b0;
			p.amber <= 1'b0;
			p.state <= 2'h0;
		end else begin
			p.green <= (st == PS_GREEN);
			p.amber <= (st == PS_AMBER) || ((st == PS_AMBER_BLINK) && p.blink);
			p.state <= st;
		end
	end
endmodule : port_indicator

// file: status_ind_pkg.sv
/*
 * Shared constants and types for the status indicator controller:
 * register map, field positions, reset values and timing counts.
 * Assumes a 250 MHz system clock and a 32-bit APB register bus.
 */
// Function
// - device health dark unpowered, green when normal
// - device health steady red on diagnostic error
// - device health blinks red on restore/comm/power fault
// - bus health dark while off line
// - bus green normal, red unconfigured, blink no exchange
// - robot port indicator shows only robot port
// - tool port indicator shows only tool port
// - robot port indicator dark without link
// - tool port indicator dark without link
// - robot port steady green on idle link
// - tool port steady green on idle link
// - port indicator blinks amber on sporadic activity
// - port steady amber on continuous connected exchange
// - restore button selects name and address erase
// - erase stays pending, done at next power cycle
package status_ind_pkg;

	// register byte offsets
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] BLINK_OFS = 8'h08;
	localparam logic [7:0] INPUT_OFS = 8'h0C;

	// control register fields
	localparam int CTRL_RESTORE_BIT = 0;
	localparam int CTRL_ENABLE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// status register fields
	localparam int ST_DEV_LSB = 0;
	localparam int ST_BUS_LSB = 2;
	localparam int ST_ROBOT_LSB = 4;
	localparam int ST_TOOL_LSB = 6;
	localparam int ST_PENDING_BIT = 8;
	localparam int ST_PHASE_BIT = 9;

	// timing in its own units, then in clock cycles
	localparam int CLK_MHZ = 250;
	localparam int BLINK_HALF_MS = 250;
	localparam int ACT_HOLD_MS = 50;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
	localparam int ACT_HOLD_CYC = ACT_HOLD_MS * 1000 * CLK_MHZ;

	// indication of a two-colour health lamp
	typedef enum logic [1:0] {
		HL_OFF,
		HL_GREEN,
		HL_RED,
		HL_RED_BLINK
	} health_t;

endpackage : status_ind_pkg

// file: status_indicator_controller.sv
/*
 * Front-panel status indicator controller: device and bus health lamps,
 * two port link/activity lamps, factory restore button and an APB slave.
 * Assumes all inputs are synchronous to i_clk and that the erase marker
 * input comes from storage that survives a power cycle.
 */
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module status_indicator_controller #(
	parameter int BLINK_HALF_CYCLES = status_ind_pkg::BLINK_HALF_CYC,
	parameter int ACT_HOLD_CYCLES = status_ind_pkg::ACT_HOLD_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,

	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,

	// device health conditions
	input wire logic i_supply_ok,
	input wire logic i_diag_error,
	input wire logic i_tool_comm_error,
	input wire logic i_input_power_fail,

	// network conditions
	input wire logic i_ip_assigned,
	input wire logic i_config_present,
	input wire logic i_cyclic_exchange,

	// robot-side port
	input wire logic i_robot_link,
	input wire logic i_robot_act,
	input wire logic i_robot_conn,

	// tool-side port
	input wire logic i_tool_link,
	input wire logic i_tool_act,
	input wire logic i_tool_conn,

	// factory restore
	input wire logic i_restore_button,
	input wire logic i_erase_stored,
	output logic o_erase_armed,
	output logic o_clear_name,
	output logic o_clear_ip,

	// lamps
	output logic o_device_health_indicator_green,
	output logic o_device_health_indicator_red,
	output logic o_bus_health_indicator_green,
	output logic o_bus_health_indicator_red,
	output logic o_robot_port_indicator_green,
	output logic o_robot_port_indicator_amber,
	output logic o_tool_port_indicator_green,
	output logic o_tool_port_indicator_amber
);
	import status_ind_pkg::*;

	// refuse periods the counters cannot serve: a half period of one cycle
	// would toggle the blink phase on every edge, one of zero would stall it,
	// and a zero hold would hide every single frame from the port lamps
	// refuse periods the counters cannot serve
	generate
		if (BLINK_HALF_CYCLES < 2 || ACT_HOLD_CYCLES < 1) begin : g_bad
			$error("blink or hold count too small");
		end
	endgenerate

	// blink period source; software may change the half period at run time,
	// and the >= compare wraps at once when a value below the count is written,
	// so a shorter period never stalls the phase for a full counter roll-over
	// blink period source
	logic [31:0] blink_cnt_q;   // cycles into the half period
	logic [31:0] blink_cnt_d;
	logic blink_q;              // common blink phase
	logic [31:0] blink_half_q;  // software half period
	wire blink_wrap = (blink_cnt_q >= blink_half_q - 32'h1);

	// control and restore state
	logic [1:0] ctrl_q;         // restore request and lamp enable
	logic btn_q;                // last button level
	logic pending_q;            // erase armed for next power cycle
	logic boot_done_q;          // first cycle after reset handled
	wire lamps_on = ctrl_q[CTRL_ENABLE_BIT];

	// apb decode; the setup cycle latches read data and raises pready for the
	// access cycle, writes land at the access edge where psel and penable are
	// both high, and an unmapped address is refused with pslverr and changes
	// nothing in the block
	// apb decode
	wire acc = i_psel && i_penable;
	wire wr = acc && i_pwrite;
	wire hit_status = (i_paddr == STATUS_OFS);
	wire hit_ctrl = (i_paddr == CTRL_OFS);
	wire hit_blink = (i_paddr == BLINK_OFS);
	wire hit_input = (i_paddr == INPUT_OFS);
	wire hit_any = hit_status || hit_ctrl || hit_blink || hit_input;
	wire wr_ctrl = wr && hit_ctrl;
	wire wr_blink = wr && hit_blink;
	wire sw_restore = wr_ctrl && i_pwdata[CTRL_RESTORE_BIT];

	// btn_q resets low, the idle level of the button, so a button held through
	// reset release reads as a press; a button held down arms once per reset,
	// on its edge, so a stuck contact re-arms after every reset
	// button edge and restore arming
	wire btn_edge = i_restore_button && !btn_q;
	wire arm = btn_edge || sw_restore;

	// health selections
	health_t dev_sel;
	health_t bus_sel;
	health_t dev_q;
	health_t bus_q;

	// port slices
	port_ind_if robot_if ();
	port_ind_if tool_if ();

	// read data
	logic [31:0] status_word;
	logic [31:0] input_word;
	logic [31:0] rdata;

	// one blink counter serves every blinking lamp so they stay in step
	// separate counters per lamp would drift apart after a period write,
	// and two lamps blinking out of phase read as a different indication
	assign blink_cnt_d = blink_wrap ? 32'h0 : blink_cnt_q + 32'h1;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else begin
			blink_cnt_q <= blink_cnt_d;
			blink_q <= blink_wrap ? !blink_q : blink_q;
		end
	end

	// blink half period register
	// a value below two is ignored rather than clamped, so a bad write
	// leaves the panel blinking exactly as it did before
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			blink_half_q <= 32'(BLINK_HALF_CYCLES);
		end else if (wr_blink && i_pwdata >= 32'h2) begin
			blink_half_q <= i_pwdata;   // too small a value is ignored
		end
	end

	// control register; the restore bit only reads back as written
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= i_pwdata[1:0];
		end
	end

	// restore is only armed here; nothing is cleared until the next power up
	// pending drives o_erase_armed, which the surroundings keep in storage
	// that survives power loss; software cannot withdraw a press, so the
	// blinking lamp tells the truth about the coming erase while it is enabled, powered and free of a diagnostic error
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			btn_q <= 1'b0;
			pending_q <= 1'b0;
		end else begin
			btn_q <= i_restore_button;
			pending_q <= pending_q || arm;
		end
	end

	// after power up, act on a marker left by the previous run
	// boot_done_q limits the clear to one pulse per reset, so a marker that
	// is slow to drop in storage cannot clear the name and address twice
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			boot_done_q <= 1'b0;
			o_clear_name <= 1'b0;
			o_clear_ip <= 1'b0;
		end else begin
			boot_done_q <= 1'b1;
			// both stores are cleared together, once
			o_clear_name <= !boot_done_q && i_erase_stored;
			o_clear_ip <= !boot_done_q && i_erase_stored;
		end
	end

	assign o_erase_armed = pending_q;

	// device health: steady red outranks every blinking cause
	// the branch order is the priority: no supply, diagnostic error, the
	// blinking causes, then normal operation
	always_comb begin
		if (!i_supply_ok) begin
			dev_sel = HL_OFF;
		end else if (i_diag_error) begin
			dev_sel = HL_RED;
		end else if (pending_q || i_tool_comm_error || i_input_power_fail) begin
			dev_sel = HL_RED_BLINK;
		end else begin
			dev_sel = HL_GREEN;
		end
	end

	// bus health from network state
	always_comb begin
		if (!i_supply_ok || !i_ip_assigned) begin
			bus_sel = HL_OFF;
		end else if (!i_config_present) begin
			bus_sel = HL_RED;
		end else if (!i_cyclic_exchange) begin
			bus_sel = HL_RED_BLINK;
		end else begin
			bus_sel = HL_GREEN;
		end
	end

	// hold the chosen indications
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			dev_q <= HL_OFF;
			bus_q <= HL_OFF;
		end else begin
			dev_q <= dev_sel;
			bus_q <= bus_sel;
		end
	end

	// health lamp drives, blink applied at the flop
	// lamps use the selection directly, so they change at the same edge as the registered codes;
	// the lamp enable gates only these last flops, so turning it off darkens
	// the panel without disturbing the indications held for the status word
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_device_health_indicator_green <= 1'b0;
			o_device_health_indicator_red <= 1'b0;
			o_bus_health_indicator_green <= 1'b0;
			o_bus_health_indicator_red <= 1'b0;
		end else begin
			o_device_health_indicator_green <= lamps_on && (dev_sel == HL_GREEN);
			o_device_health_indicator_red <= lamps_on && ((dev_sel == HL_RED) ||
				((dev_sel == HL_RED_BLINK) && blink_q));
			o_bus_health_indicator_green <= lamps_on && (bus_sel == HL_GREEN);
			o_bus_health_indicator_red <= lamps_on && ((bus_sel == HL_RED) ||
				((bus_sel == HL_RED_BLINK) && blink_q));
		end
	end

	// each slice sees only its own port's conditions
	// supply gates the link so that an unpowered module shows no port lamp
	// even while the port still reports link; activity needs no such gate
	assign robot_if.link = i_supply_ok && i_robot_link;
	assign robot_if.act = i_robot_act;
	assign robot_if.conn = i_robot_conn;
	assign robot_if.blink = blink_q;
	assign robot_if.hold = 32'(ACT_HOLD_CYCLES);
	assign tool_if.link = i_supply_ok && i_tool_link;
	assign tool_if.act = i_tool_act;
	assign tool_if.conn = i_tool_conn;
	assign tool_if.blink = blink_q;
	assign tool_if.hold = 32'(ACT_HOLD_CYCLES);

	// robot-side lamp
	port_indicator u_robot (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.p(robot_if)
	);

	// tool-side lamp
	port_indicator u_tool (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.p(tool_if)
	);

	// port lamp drives, one flop after the slice so the enable gates cleanly
	// this costs one more cycle of latency on the port lamps, which no
	// operator can see, in exchange for outputs straight from flops
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_robot_port_indicator_green <= 1'b0;
			o_robot_port_indicator_amber <= 1'b0;
			o_tool_port_indicator_green <= 1'b0;
			o_tool_port_indicator_amber <= 1'b0;
		end else begin
			o_robot_port_indicator_green <= lamps_on && robot_if.green;
			o_robot_port_indicator_amber <= lamps_on && robot_if.amber;
			o_tool_port_indicator_green <= lamps_on && tool_if.green;
			o_tool_port_indicator_amber <= lamps_on && tool_if.amber;
		end
	end

	// status word shows the block's own chosen indications
	always_comb begin
		status_word = 32'h0;
		status_word[ST_DEV_LSB +: 2] = dev_q;
		status_word[ST_BUS_LSB +: 2] = bus_q;
		status_word[ST_ROBOT_LSB +: 2] = robot_if.state;
		status_word[ST_TOOL_LSB +: 2] = tool_if.state;
		status_word[ST_PENDING_BIT] = pending_q;
		status_word[ST_PHASE_BIT] = blink_q;
	end

	// raw condition inputs, for bring-up
	assign input_word = {19'h0, i_restore_button, i_tool_conn, i_tool_link,
		i_robot_conn, i_robot_link, i_cyclic_exchange, i_config_present,
		i_ip_assigned, i_input_power_fail, i_tool_comm_error, i_diag_error,
		i_supply_ok, i_erase_stored};

	// read mux; unmapped addresses read zero
	assign rdata = hit_status ? status_word :
		hit_ctrl ? {30'h0, ctrl_q} :
		hit_blink ? blink_half_q :
		hit_input ? input_word : 32'h0;

	// answer in the access cycle; registering the reply keeps it from a flop
	// while the first access cycle still completes with zero waits
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_prdata <= (i_psel && !i_penable && !i_pwrite) ? rdata : o_prdata;
			o_pready <= i_psel && !i_penable;
			o_pslverr <= i_psel && !i_penable && !hit_any;
		end
	end

endmodule : status_indicator_controller

// file: status_indicator_controller_asserts.sv
/* lamp and restore relations checked at the controller ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module status_indicator_controller_asserts (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// conditions
	input wire logic i_supply_ok,
	input wire logic i_diag_error,
	input wire logic i_tool_comm_error,
	input wire logic i_input_power_fail,
	input wire logic i_ip_assigned,
	input wire logic i_config_present,
	input wire logic i_cyclic_exchange,
	input wire logic i_robot_link,
	input wire logic i_tool_link,
	input wire logic i_restore_button,
	// watched outputs
	input wire logic o_erase_armed,
	input wire logic o_pready,
	input wire logic o_device_health_indicator_green,
	input wire logic o_device_health_indicator_red,
	input wire logic o_bus_health_indicator_green,
	input wire logic o_bus_health_indicator_red,
	input wire logic o_robot_port_indicator_green,
	input wire logic o_robot_port_indicator_amber,
	input wire logic o_tool_port_indicator_green,
	input wire logic o_tool_port_indicator_amber
);
	// lamp pairs as {green, red} or {green, amber}
	wire [1:0] dev = {o_device_health_indicator_green, o_device_health_indicator_red};
	wire [1:0] bus = {o_bus_health_indicator_green, o_bus_health_indicator_red};
	wire [1:0] rob = {o_robot_port_indicator_green, o_robot_port_indicator_amber};
	wire [1:0] tol = {o_tool_port_indicator_green, o_tool_port_indicator_amber};
	wire on = i_supply_ok;
	// faults that make the device lamp blink
	wire flt = i_tool_comm_error || i_input_power_fail;
	default clocking cb @(posedge i_clk); endclocking
	// outputs still show reset values one edge after release, so skip that edge too
	logic srst_q; // reset level seen at the last edge
	always_ff @(posedge i_clk) begin
		srst_q <= i_srst;
	end
	default disable iff (i_srst || srst_q);
	chk_no_power: assert property (!on |=> dev == 2'h0 && bus == 2'h0)
		else $error("health lamp lit without supply");
	chk_diag_red: assert property (on && i_diag_error |=> dev == 2'h1)
		else $error("diagnostic error not steady red");
	// a button edge or a register write may arm in the same cycle, so both are excluded
	chk_dev_green: assert property (on && !i_diag_error && !flt && !o_erase_armed
		&& !i_restore_button && !o_pready |=> dev == 2'h2)
		else $error("device lamp not green");
	chk_bus_dark: assert property (!i_ip_assigned |=> bus == 2'h0)
		else $error("bus lamp lit while off line");
	chk_bus_red: assert property (on && i_ip_assigned && !i_config_present
		|=> bus == 2'h1)
		else $error("bus lamp not red without configuration");
	chk_bus_green: assert property (on && i_ip_assigned && i_config_present
		&& i_cyclic_exchange |=> bus == 2'h2)
		else $error("bus lamp not green");
	chk_robot_dark: assert property (!i_robot_link |=> ##1 rob == 2'h0)
		else $error("robot lamp lit without link");
	chk_tool_dark: assert property (!i_tool_link |=> ##1 tol == 2'h0)
		else $error("tool lamp lit without link");
	chk_arm_set: assert property ($rose(i_restore_button) |=> o_erase_armed)
		else $error("button did not arm erase");
	chk_arm_held: assert property (o_erase_armed |=> o_erase_armed)
		else $error("pending erase dropped");
	chk_blink_phase: assert property (on && !i_diag_error && flt && i_ip_assigned
		&& i_config_present && !i_cyclic_exchange |=> dev[0] == bus[0])
		else $error("blink phases differ");
endmodule : status_indicator_controller_asserts

bind status_indicator_controller status_indicator_controller_asserts chk_u (.*);

// file: status_indicator_controller_tb.sv
/* bench for the status indicator controller: lamp tables, restore
   button and register bus. assumes short blink and hold counts. */
`timescale 1ns/1ps
module status_indicator_controller_tb;
	import status_ind_pkg::*;
	logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata;
	logic o_pready, o_pslverr, o_erase_armed, o_clear_name, o_clear_ip;
	logic i_robot_act = 0, i_tool_act = 0, i_erase_stored = 0, press = 0, pr = 0, pt = 0;
	logic i_restore_button;
	logic [10:0] cond = 11'h000; // supply diag comm pwr ip cfg cyc rlink rconn tlink tconn
	wire [7:0] lamps; // one bit per lamp drive
	logic [7:0] nred;
	int n_fail = 0, total_checks = 0, cyc = 0;
	localparam logic [10:0] N = 11'h2F1; // healthy, both links up

	status_indicator_controller #(.BLINK_HALF_CYCLES(8), .ACT_HOLD_CYCLES(4)) dut_u (.*,
		.i_supply_ok(cond[0]), .i_diag_error(cond[1]), .i_tool_comm_error(cond[2]),
		.i_input_power_fail(cond[3]), .i_ip_assigned(cond[4]), .i_config_present(cond[5]),
		.i_cyclic_exchange(cond[6]), .i_robot_link(cond[7]), .i_robot_conn(cond[8]),
		.i_tool_link(cond[9]), .i_tool_conn(cond[10]),
		.o_device_health_indicator_green(lamps[7]), .o_device_health_indicator_red(lamps[6]),
		.o_bus_health_indicator_green(lamps[5]), .o_bus_health_indicator_red(lamps[4]),
		.o_robot_port_indicator_green(lamps[3]), .o_robot_port_indicator_amber(lamps[2]),
		.o_tool_port_indicator_green(lamps[1]), .o_tool_port_indicator_amber(lamps[0]));
	operator_model op_u (.i_clk(i_clk), .i_press(press), .i_red(lamps[6]),
		.o_button(i_restore_button), .o_red_changes(nred));

	initial forever #2 i_clk = ~i_clk;
	// activity pulses every other cycle stay inside the hold time; timeout guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		i_robot_act <= pr && !i_robot_act;
		i_tool_act <= pt && !i_tool_act;
		if (cyc == 6000) begin
			n_fail++;
			$display("CHECK FAILED at %0t: bench timeout", $time);
			summarize();
		end
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; waits for pready, takes data at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge i_clk);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1;
		// no local limit: only the bench timeout ends a wait
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask : apb

	// set conditions, settle, then watch 40 cycles: masked lamps and change count
	task automatic lamp_case(input logic [10:0] c, input logic ra, ta,
		input logic [7:0] m, x, input logic b);
		int ch;
		logic [7:0] v;
		@(posedge i_clk);
		cond <= c;
		pr <= ra;
		pt <= ta;
		repeat (10) @(posedge i_clk);
		ch = 0;
		v = lamps;
		repeat (40) begin
			@(posedge i_clk);
			ch += int'(lamps !== v);
			v = lamps;
		end
		chk(33'(v & m), 33'(x));
		chk(33'(b ? (ch >= 4 && ch <= 5) : ch == 0), 33'h1);
	endtask : lamp_case

	task automatic t_regs();
		logic [31:0] r;
		logic e;
		apb(0, CTRL_OFS, 32'h0, r, e);
		chk({e, r}, 33'h2);
		apb(1, BLINK_OFS, 32'h1, r, e);
		apb(0, BLINK_OFS, 32'h0, r, e);
		chk({e, r}, 33'h8);
		apb(1, BLINK_OFS, 32'h6, r, e);
		apb(0, BLINK_OFS, 32'h0, r, e);
		chk({e, r}, 33'h6);
		apb(1, BLINK_OFS, 32'h8, r, e);
		apb(0, 8'h10, 32'h0, r, e);
		chk({e, r}, 33'h100000000);
		// lamp enable: blinking device lamp, bus off line, then the panel dark
		lamp_case(11'h285, 0, 0, 8'hBF, 8'h0A, 1);
		apb(1, CTRL_OFS, 32'h0, r, e);
		lamp_case(11'h285, 0, 0, 8'hFF, 8'h00, 0);
		apb(1, CTRL_OFS, 32'h2, r, e);
		apb(0, CTRL_OFS, 32'h0, r, e);
		chk({e, r}, 33'h2);
	endtask : t_regs

	task automatic t_dev();
		lamp_case(11'h000, 0, 0, 8'hFF, 8'h00, 0);
		lamp_case(N, 0, 0, 8'hFF, 8'hAA, 0);
		lamp_case(N | 11'h002, 0, 0, 8'hFF, 8'h6A, 0);
		lamp_case(N | 11'h004, 0, 0, 8'hBF, 8'h2A, 1);
		lamp_case(N | 11'h008, 0, 0, 8'hBF, 8'h2A, 1);
		lamp_case(N | 11'h006, 0, 0, 8'hFF, 8'h6A, 0);
	endtask : t_dev

	task automatic t_bus();
		lamp_case(N & ~11'h010, 0, 0, 8'hFF, 8'h8A, 0);
		lamp_case(N & ~11'h020, 0, 0, 8'hFF, 8'h9A, 0);
		lamp_case(N & ~11'h040, 0, 0, 8'hEF, 8'h8A, 1);
		lamp_case((N & ~11'h040) | 11'h004, 0, 0, 8'hAF, 8'h0A, 1);
	endtask : t_bus

	task automatic t_port();
		lamp_case(N & ~11'h080, 0, 0, 8'hFF, 8'hA2, 0);
		lamp_case(N & ~11'h200, 0, 0, 8'hFF, 8'hA8, 0);
		lamp_case(N, 1, 0, 8'hFB, 8'hA2, 1);
		lamp_case(N | 11'h100, 1, 0, 8'hFF, 8'hA6, 0);
		lamp_case(N | 11'h400, 0, 1, 8'hFF, 8'hA9, 0);
		lamp_case(N, 0, 1, 8'hFE, 8'hA8, 1);
	endtask : t_port

	// press, check pending and blink, then power cycle with the marker kept
	task automatic t_restore();
		logic [31:0] r;
		logic e;
		int n0;
		@(posedge i_clk);
		press <= 1;
		repeat (3) @(posedge i_clk);
		press <= 0;
		n0 = nred;
		lamp_case(N, 0, 0, 8'hBF, 8'h2A, 1);
		chk(33'(nred - n0 >= 4), 33'h1);
		chk({o_erase_armed, o_clear_name, o_clear_ip}, 33'h4);
		apb(0, STATUS_OFS, 32'h0, r, e);
		chk(33'(r[ST_PENDING_BIT]), 33'h1);
		@(posedge i_clk);
		i_srst <= 1;
		i_erase_stored <= 1;
		repeat (3) @(posedge i_clk);
		i_srst <= 0;
		repeat (2) @(posedge i_clk);
		chk({o_clear_name, o_clear_ip, o_erase_armed}, 33'h6);
		@(posedge i_clk);
		i_erase_stored <= 0;
		chk({o_clear_name, o_clear_ip}, 33'h0);
		apb(1, CTRL_OFS, 32'h3, r, e);
		@(posedge i_clk);
		chk(33'(o_erase_armed), 33'h1);
	endtask : t_restore

	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	initial begin
		repeat (20) @(posedge i_clk);
		i_srst <= 0;
		t_regs();
		t_dev();
		t_bus();
		t_port();
		t_restore();
		summarize();
	end
endmodule : status_indicator_controller_tb
